// ---- rtl/hdlc_tx_count_test.sv ----
// transmit byte counter, loopback paths and test controls of the hdlc controller
// assumes receiver, transmitter and rx fifo are on-chip logic on clk;
// receiveBitClock, serialTestIn and lineRxIn are pins and are synchronised here
`timescale 1ns/1ps
module hdlc_tx_count_test #(
  parameter int unsigned FIFO_DEPTH = hdlc_tc_pkg::TX_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire hdlc_tc_pkg::cpu_req_t cpuReq,
  output logic [7:0] rdData,
  input wire hdlc_tc_pkg::tagged_byte_t cpuTx,
  input wire logic cpuTxValid,
  output logic cpuTxReady,
  input wire logic rxFifoRdStb,
  output logic rxFifoRdReq,
  output logic [1:0] tagReadback,
  input wire logic repeatCountBit,
  input wire logic transmitterEnableBit,
  input wire hdlc_tc_pkg::rx_byte_t rxIn,
  input wire logic rxInValid,
  output hdlc_tc_pkg::tagged_byte_t rxFifoWr,
  output logic rxFifoWrValid,
  output hdlc_tc_pkg::tagged_byte_t txOut,
  output logic txOutValid,
  input wire logic txOutReady,
  input wire logic receiveBitClock,
  input wire logic serialTestIn,
  input wire logic [15:0] addrCompare,
  output logic crcMatchFlag,
  output logic addressMatchFlag,
  input wire logic txSerial,
  input wire logic lineRxIn,
  output logic rxSerialOut,
  output logic hdlcHeldInReset
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] length;
    logic [7:0] count;
    logic [7:0] ctrl;
    logic [1:0] zeroWrites;
    logic [7:0] rdData;
    logic [1:0] tagRb;
    logic rxRdReq;
    hdlc_tc_pkg::tagged_byte_t cpuPend;
    logic cpuPendV;
    hdlc_tc_pkg::tagged_byte_t loopPend;
    logic loopPendV;
    logic cpuReady;
    hdlc_tc_pkg::tagged_byte_t rxWr;
    logic rxWrV;
    hdlc_tc_pkg::tagged_byte_t txOut;
    logic txOutV;
    logic clkS1;
    logic clkS2;
    logic clkS3;
    logic sdS1;
    logic sdS2;
    logic lineS1;
    logic lineS2;
    logic [15:0] crcShift;
    logic [4:0] crcCnt;
    logic [15:0] addrShift;
    logic [4:0] addrCnt;
    logic crcMatch;
    logic addrMatch;
    logic rxSerial;
  } state_t;

  localparam state_t ST_RESET = '{
    length: hdlc_tc_pkg::TX_COUNT_RESET,
    count: hdlc_tc_pkg::TX_COUNT_RESET,
    ctrl: hdlc_tc_pkg::TEST_CTRL_RESET,
    default: '0
  };

  state_t s_q;
  state_t s_d;

  // serial test step: shift one bit in until the compare point is reached
  function automatic logic [20:0] serialStep(input logic [15:0] sr, input logic [4:0] cnt,
                                             input logic enable, input logic stepEdge, input logic bitIn);
    logic [20:0] r;
    r = {cnt, sr};
    if (!enable) begin
      r = {5'h00, sr};
    end else if (stepEdge && (cnt < hdlc_tc_pkg::SERIAL_TEST_BITS)) begin
      r = {cnt + 5'h01, sr[14:0], bitIn};
    end
    return r;
  endfunction

  logic softRst;
  logic rx_to_tx_loop_bit;
  logic fifoTest;
  logic cpuAccept;
  logic cpuWriteNormal;
  logic rxEdge;
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic popToTx;
  logic popToCpu;
  hdlc_tc_pkg::tagged_byte_t fifoIn;
  hdlc_tc_pkg::tagged_byte_t fifoOut;

  assign softRst = s_q.ctrl[hdlc_tc_pkg::SOFT_RST_POS];
  assign rx_to_tx_loop_bit = s_q.ctrl[hdlc_tc_pkg::RT_LOOP_POS];
  assign fifoTest = s_q.ctrl[hdlc_tc_pkg::FIFO_TEST_POS];
  assign cpuAccept = cpuTxValid && s_q.cpuReady;
  assign cpuWriteNormal = cpuAccept && !fifoTest;
  assign rxEdge = s_q.clkS2 && !s_q.clkS3;

  // ****************************************
  // transmit fifo path
  // ****************************************
  // looped bytes win the fifo port: the receiver cannot be stalled, the processor can
  assign fifoInValid = s_q.loopPendV || s_q.cpuPendV;
  assign fifoIn = s_q.loopPendV ? s_q.loopPend : s_q.cpuPend;
  assign popToTx = !fifoTest && transmitterEnableBit && (!s_q.txOutV || txOutReady);
  assign popToCpu = fifoTest && rxFifoRdStb;
  assign fifoOutReady = fifoOutValid && (popToTx || popToCpu);

  tag_fifo #(
    .WIDTH($bits(hdlc_tc_pkg::tagged_byte_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_tag_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .clear(softRst),
    .inValid(fifoInValid),
    .inData(fifoIn),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOut),
    .outReady(fifoOutReady)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [20:0] crcStep;
    logic [20:0] addrStep;
    crcStep = '0;
    addrStep = '0;
    s_d = s_q;
    s_d.rxRdReq = 1'b0;
    s_d.rxWrV = 1'b0;

    // pin synchronisers; first stages feed only the second stages
    s_d.clkS1 = receiveBitClock;
    s_d.clkS2 = s_q.clkS1;
    s_d.clkS3 = s_q.clkS2;
    s_d.sdS1 = serialTestIn;
    s_d.sdS2 = s_q.sdS1;
    s_d.lineS1 = lineRxIn;
    s_d.lineS2 = s_q.lineS1;

    // register writes
    if (cpuReq.wr && (cpuReq.addr == hdlc_tc_pkg::TX_COUNT_ADDR)) begin
      s_d.length = cpuReq.data;
      s_d.count = cpuReq.data;
    end
    if (cpuReq.wr && (cpuReq.addr == hdlc_tc_pkg::TEST_CTRL_ADDR)) begin
      s_d.ctrl[6:0] = cpuReq.data[6:0];
      if (cpuReq.data[hdlc_tc_pkg::SOFT_RST_POS]) begin
        s_d.ctrl[hdlc_tc_pkg::SOFT_RST_POS] = 1'b1;
        s_d.zeroWrites = 2'h0;
      end else if (softRst) begin
        // a single stray zero must not release the controller
        s_d.zeroWrites = s_q.zeroWrites + 2'h1;
        if (s_d.zeroWrites == hdlc_tc_pkg::ZERO_WRITES_TO_CLEAR) begin
          s_d.ctrl[hdlc_tc_pkg::SOFT_RST_POS] = 1'b0;
          s_d.zeroWrites = 2'h0;
        end
      end
    end

    // register and fifo reads
    if (cpuReq.rd) begin
      unique case (cpuReq.addr)
        hdlc_tc_pkg::TX_COUNT_ADDR: s_d.rdData = s_q.count;
        hdlc_tc_pkg::TEST_CTRL_ADDR: s_d.rdData = s_q.ctrl;
        default: s_d.rdData = 8'h00;
      endcase
    end
    if (rxFifoRdStb) begin
      if (fifoTest) begin
        s_d.rdData = fifoOutValid ? fifoOut.data : 8'h00;
        s_d.tagRb = fifoOutValid ? {fifoOut.abort, fifoOut.eop} : 2'h0;
      end else begin
        s_d.rxRdReq = 1'b1;
      end
    end

    // pending stages drain into the transmit fifo
    if (fifoInReady && s_q.loopPendV) begin
      s_d.loopPendV = 1'b0;
    end else if (fifoInReady && s_q.cpuPendV) begin
      s_d.cpuPendV = 1'b0;
    end

    // processor writes aimed at the transmit fifo
    if (cpuAccept && fifoTest) begin
      s_d.rxWr = cpuTx;
      s_d.rxWrV = 1'b1;
    end
    if (cpuWriteNormal) begin
      s_d.cpuPend = cpuTx;
      s_d.cpuPend.eop = cpuTx.eop || (s_q.count == 8'h01);
      s_d.cpuPendV = 1'b1;
      if (s_q.count == 8'h01) begin
        s_d.count = repeatCountBit ? s_q.length : 8'h00;
      end else if (s_q.count != 8'h00) begin
        s_d.count = s_q.count - 8'h01;
      end
    end
    s_d.cpuReady = !s_d.cpuPendV;

    // received bytes; error status plays no part in the copy
    if (rxInValid && !rxIn.ctrl && !(cpuAccept && fifoTest)) begin
      s_d.rxWr = rxIn.body;
      s_d.rxWrV = 1'b1;
      if (rx_to_tx_loop_bit) begin
        s_d.loopPend = rxIn.body;
        s_d.loopPendV = 1'b1;
      end
    end

    // transmitter output stage
    if (s_q.txOutV && txOutReady) begin
      s_d.txOutV = 1'b0;
    end
    if (fifoOutValid && popToTx) begin
      s_d.txOut = fifoOut;
      s_d.txOutV = 1'b1;
    end

    // serial test access to the compare registers
    crcStep = serialStep(s_q.crcShift, s_q.crcCnt, s_q.ctrl[hdlc_tc_pkg::CRC_TEST_POS], rxEdge, s_q.sdS2);
    s_d.crcCnt = crcStep[20:16];
    s_d.crcShift = crcStep[15:0];
    addrStep = serialStep(s_q.addrShift, s_q.addrCnt, s_q.ctrl[hdlc_tc_pkg::ADDR_TEST_POS], rxEdge, s_q.sdS2);
    s_d.addrCnt = addrStep[20:16];
    s_d.addrShift = addrStep[15:0];
    // full 16-bit compare, so a single corrupted bit fails the match
    s_d.crcMatch = (s_q.crcShift == hdlc_tc_pkg::CRC_REMAINDER);
    s_d.addrMatch = (s_q.addrShift == addrCompare);

    // receiver serial input source; enables are the processor's job
    s_d.rxSerial = s_q.ctrl[hdlc_tc_pkg::TR_LOOP_POS] ? txSerial : s_q.lineS2;

    // soft reset keeps only the control register, zero-write count, read data, tag readback, pin stages and receiver serial input
    if (s_d.ctrl[hdlc_tc_pkg::SOFT_RST_POS]) begin
      s_d = '{
        ctrl: s_d.ctrl,
        zeroWrites: s_d.zeroWrites,
        rdData: s_d.rdData,
        tagRb: s_d.tagRb,
        clkS1: s_d.clkS1,
        clkS2: s_d.clkS2,
        clkS3: s_d.clkS3,
        sdS1: s_d.sdS1,
        sdS2: s_d.sdS2,
        lineS1: s_d.lineS1,
        lineS2: s_d.lineS2,
        rxSerial: s_d.rxSerial,
        length: ST_RESET.length,
        count: ST_RESET.count,
        default: '0
      };
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdData = s_q.rdData;
  assign tagReadback = s_q.tagRb;
  assign rxFifoRdReq = s_q.rxRdReq;
  assign cpuTxReady = s_q.cpuReady;
  assign rxFifoWr = s_q.rxWr;
  assign rxFifoWrValid = s_q.rxWrV;
  assign txOut = s_q.txOut;
  assign txOutValid = s_q.txOutV;
  assign crcMatchFlag = s_q.crcMatch;
  assign addressMatchFlag = s_q.addrMatch;
  assign rxSerialOut = s_q.rxSerial;
  assign hdlcHeldInReset = s_q.ctrl[hdlc_tc_pkg::SOFT_RST_POS];

  // ****************************************
  // assertions
  // ****************************************
  logic ctrlWrite;
  logic zeroWrite;
  assign ctrlWrite = cpuReq.wr && (cpuReq.addr == hdlc_tc_pkg::TEST_CTRL_ADDR);
  assign zeroWrite = ctrlWrite && !cpuReq.data[hdlc_tc_pkg::SOFT_RST_POS];

  sequence s_plainTxWrite;
    cpuWriteNormal && !softRst && !ctrlWrite && !(cpuReq.wr && cpuReq.addr == hdlc_tc_pkg::TX_COUNT_ADDR);
  endsequence

  sequence s_firstZero;
    softRst && zeroWrite && (s_q.zeroWrites == 2'h0);
  endsequence

  property p_count_dec;
    @(posedge clk) disable iff (!rst_b)
    s_plainTxWrite and (s_q.count > 8'h01) |=> (s_q.count == $past(s_q.count) - 8'h01);
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("byte count did not decrement");

  property p_eop_tag;
    @(posedge clk) disable iff (!rst_b)
    s_plainTxWrite and (s_q.count == 8'h01) |=> s_q.cpuPendV && s_q.cpuPend.eop;
  endproperty
  a_eop_tag: assert property (p_eop_tag) else $error("last byte not tagged end of packet");

  property p_reload;
    @(posedge clk) disable iff (!rst_b)
    s_plainTxWrite and (s_q.count == 8'h01) and repeatCountBit |=> (s_q.count == $past(s_q.length));
  endproperty
  a_reload: assert property (p_reload) else $error("count not reloaded in repeat mode");

  property p_soft_hold;
    @(posedge clk) disable iff (!rst_b)
    softRst |-> !s_q.txOutV && !s_q.cpuPendV && !s_q.loopPendV && !rxFifoWrValid && hdlcHeldInReset;
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("controller active under soft reset");

  property p_zero_twice;
    @(posedge clk) disable iff (!rst_b)
    s_firstZero ##1 (!ctrlWrite)[*1] ##1 (zeroWrite && softRst) |=> !softRst;
  endproperty
  a_zero_twice: assert property (p_zero_twice) else $error("soft reset kept after two zero writes");

  property p_one_zero;
    @(posedge clk) disable iff (!rst_b)
    s_firstZero |=> softRst;
  endproperty
  a_one_zero: assert property (p_one_zero) else $error("soft reset cleared by one zero write");

  property p_rt_copy;
    @(posedge clk) disable iff (!rst_b)
    rxInValid && !rxIn.ctrl && rx_to_tx_loop_bit && !softRst && !ctrlWrite && !(cpuAccept && fifoTest)
      |=> s_q.loopPendV && rxFifoWrValid && (s_q.loopPend == $past(rxIn.body));
  endproperty
  a_rt_copy: assert property (p_rt_copy) else $error("received byte not looped to transmit");

  property p_ctrl_skip;
    @(posedge clk) disable iff (!rst_b)
    rxInValid && rxIn.ctrl && !(cpuAccept && fifoTest) |=> !rxFifoWrValid;
  endproperty
  a_ctrl_skip: assert property (p_ctrl_skip) else $error("flag or crc byte copied");

  property p_crc_stop;
    @(posedge clk) disable iff (!rst_b)
    (s_q.crcCnt == hdlc_tc_pkg::SERIAL_TEST_BITS) && s_q.ctrl[hdlc_tc_pkg::CRC_TEST_POS] && !softRst
      && !ctrlWrite |=> $stable(s_q.crcShift) && $stable(s_q.crcCnt);
  endproperty
  a_crc_stop: assert property (p_crc_stop) else $error("crc shift ran past sixteen bits");

  property p_crc_match;
    @(posedge clk) disable iff (!rst_b)
    !softRst && !ctrlWrite ##1 1'b1 |-> crcMatchFlag == ($past(s_q.crcShift) == hdlc_tc_pkg::CRC_REMAINDER);
  endproperty
  a_crc_match: assert property (p_crc_match) else $error("crc match flag wrong");

  property p_fifo_test;
    @(posedge clk) disable iff (!rst_b)
    cpuAccept && fifoTest && !softRst && !ctrlWrite |=> rxFifoWrValid && (rxFifoWr == $past(cpuTx)) && !s_q.cpuPendV;
  endproperty
  a_fifo_test: assert property (p_fifo_test) else $error("test write not redirected to rx fifo");

  property p_tr_loop;
    @(posedge clk) disable iff (!rst_b)
    s_q.ctrl[hdlc_tc_pkg::TR_LOOP_POS] |=> (rxSerialOut == $past(txSerial));
  endproperty
  a_tr_loop: assert property (p_tr_loop) else $error("transmit serial not looped to receiver");

endmodule

// ---- inc/hdlc_tc_pkg.sv ----
// constants and carrier types for the hdlc transmit counter and test control block
// assumes one 125 MHz clock domain and a synchronous active-low reset
package hdlc_tc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [4:0] TX_COUNT_ADDR = 5'h19;
  localparam logic [4:0] TEST_CTRL_ADDR = 5'h1A;
  localparam logic [7:0] TX_COUNT_RESET = 8'h00;
  localparam logic [7:0] TEST_CTRL_RESET = 8'h00;

  // ****************************************
  // test control bit positions
  // ****************************************
  localparam int unsigned SOFT_RST_POS = 7;
  localparam int unsigned RT_LOOP_POS = 6;
  localparam int unsigned CRC_TEST_POS = 3;
  localparam int unsigned FIFO_TEST_POS = 2;
  localparam int unsigned ADDR_TEST_POS = 1;
  localparam int unsigned TR_LOOP_POS = 0;

  // ****************************************
  // counts and patterns
  // ****************************************
  localparam logic [1:0] ZERO_WRITES_TO_CLEAR = 2'h2;
  localparam logic [4:0] SERIAL_TEST_BITS = 5'h10;
  localparam logic [15:0] CRC_REMAINDER = 16'hF0B8;
  localparam int unsigned TX_FIFO_DEPTH = 8;

  // byte with its frame tags as it sits in either fifo
  typedef struct packed {
    logic abort;
    logic eop;
    logic [7:0] data;
  } tagged_byte_t;

  // byte from the receiver; ctrl marks flag or crc bytes
  typedef struct packed {
    tagged_byte_t body;
    logic ctrl;
  } rx_byte_t;

  // one-cycle register access from the processor port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] data;
  } cpu_req_t;

endpackage

// ---- rtl/tag_fifo.sv ----
// synchronous fifo with valid and ready on both sides
// assumes producer and consumer share clk; clear empties it at once
`timescale 1ns/1ps
module tag_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] fill;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic push;
  logic pop;

  assign inReady = (s_q.fill != FULL);
  assign outValid = (s_q.fill != '0);
  assign outData = s_q.mem[s_q.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wrPtr] = inData;
      s_d.wrPtr = (s_q.wrPtr == LAST) ? '0 : s_q.wrPtr + 1'b1;
    end
    if (pop) begin
      s_d.rdPtr = (s_q.rdPtr == LAST) ? '0 : s_q.rdPtr + 1'b1;
    end
    s_d.fill = s_q.fill + (AW + 1)'(push) - (AW + 1)'(pop);
    if (clear) begin
      s_d.wrPtr = '0;
      s_d.rdPtr = '0;
      s_d.fill = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ---- tb/hdlc_far_end.sv ----
// far-end model: the hdlc transmitter taking bytes from the block and driving its serial line
// assumes the block's clk; slow makes it stall at random like a busy transmitter
`timescale 1ns/1ps
module hdlc_far_end (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic txOutValid,
  output logic txOutReady,
  output logic txSerial
);
  // ****************************************
  // byte acceptance and serial line
  // ****************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      txOutReady <= 1'b0;
      txSerial <= 1'b1;
    end else begin
      // when slow, ready drops after each handshake, so a byte right behind an accepted one always sees a stall first; otherwise ready stays high
      txOutReady <= slow ? (!(txOutValid && txOutReady) && ($urandom % 3 == 0)) : 1'b1;
      txSerial <= 1'($urandom);
    end
  end
endmodule

// ---- tb/test_hdlc_tx_count_test.sv ----
// self-checking bench for the transmit counter, loopbacks and test controls
// assumes the far-end model in hdlc_far_end; inputs change on falling edges
`timescale 1ns/1ps
module test_hdlc_tx_count_test;
  // ****************************************
  // harness
  // ****************************************
  logic clk, rst_b, cpuTxValid, rxFifoRdStb, repeatCountBit, transmitterEnableBit, rxInValid;
  logic receiveBitClock, serialTestIn, lineRxIn, txSerial, txOutReady, slow, rdLast, txSerPrev;
  logic cpuTxReady, rxFifoRdReq, rxFifoWrValid, txOutValid, crcMatchFlag, addressMatchFlag;
  logic rxSerialOut, hdlcHeldInReset;
  logic [7:0] rdData;
  logic [1:0] tagReadback;
  logic [15:0] addrCompare;
  logic [10:0] e;
  hdlc_tc_pkg::cpu_req_t cpuReq;
  hdlc_tc_pkg::tagged_byte_t cpuTx, rxFifoWr, txOut;
  hdlc_tc_pkg::tagged_byte_t fb[3];
  hdlc_tc_pkg::rx_byte_t rxIn;
  hdlc_tc_pkg::tagged_byte_t txQ[$], rxQ[$];
  logic [10:0] rdQ[$];
  int mismatches = 0;
  int testsRun = 0;
  int cnt, len;

  hdlc_tx_count_test #(.FIFO_DEPTH(8)) u_hdlc_tx_count_test (.clk, .rst_b, .cpuReq, .rdData, .cpuTx,
    .cpuTxValid, .cpuTxReady, .rxFifoRdStb, .rxFifoRdReq, .tagReadback, .repeatCountBit,
    .transmitterEnableBit, .rxIn, .rxInValid, .rxFifoWr, .rxFifoWrValid, .txOut, .txOutValid,
    .txOutReady, .receiveBitClock, .serialTestIn, .addrCompare, .crcMatchFlag, .addressMatchFlag,
    .txSerial, .lineRxIn, .rxSerialOut, .hdlcHeldInReset);
  hdlc_far_end u_hdlc_far_end (.clk, .rst_b, .slow, .txOutValid, .txOutReady, .txSerial);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic bad(string m);
    mismatches++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp, string m);
    testsRun++;
    if (got !== exp) bad(m);
  endtask
  task automatic testDone();
    $display("mismatches %0d, checks %0d", mismatches, testsRun);
    if (mismatches == 0 && testsRun > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    cpuReq = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    cpuReq = '0;
    @(negedge clk);
  endtask
  task automatic rd(logic [4:0] a, logic [7:0] x);
    rdQ.push_back({3'b000, x});
    cpuReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    cpuReq = '0;
    @(negedge clk);
  endtask
  // req: the strobe must be forwarded to the rx fifo (normal mode) or kept here (fifo test)
  task automatic pop(logic [9:0] x, logic req = 1'b0);
    rdQ.push_back({1'b1, x});
    rxFifoRdStb = 1'b1;
    @(negedge clk);
    rxFifoRdStb = 1'b0;
    chk(16'(rxFifoRdReq), 16'(req), "rx fifo read request");
    @(negedge clk);
  endtask
  // dst 0: expect it at the transmitter, 1: at the rx fifo, 2: it stays queued
  task automatic txWr(hdlc_tc_pkg::tagged_byte_t b, int dst);
    int n;
    hdlc_tc_pkg::tagged_byte_t x;
    n = 0;
    x = b;
    cpuTx = b;
    cpuTxValid = 1'b1;
    while (cpuTxReady !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n == 50) bad("write not taken");
    if (cnt == 1 && dst != 1) x.eop = 1'b1;
    if (dst != 1) cnt = (cnt == 1) ? (repeatCountBit ? len : 0) : (cnt > 0 ? cnt - 1 : 0);
    if (dst == 0) txQ.push_back(x);
    if (dst == 1) rxQ.push_back(b);
    @(negedge clk);
    cpuTxValid = 1'b0;
    @(negedge clk);
  endtask
  task automatic rxByte(hdlc_tc_pkg::rx_byte_t b);
    if (!b.ctrl) begin
      rxQ.push_back(b.body);
      txQ.push_back(b.body);
    end
    rxIn = b;
    rxInValid = 1'b1;
    @(negedge clk);
    rxInValid = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic shift(logic [15:0] v, int nb);
    for (int i = 15; i > 15 - nb; i--) begin
      serialTestIn = v[i];
      repeat (2) @(negedge clk);
      receiveBitClock = 1'b1;
      repeat (4) @(negedge clk);
      receiveBitClock = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask

  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge clk) begin
    rdLast <= cpuReq.rd | rxFifoRdStb;
    txSerPrev <= txSerial;
  end
  always @(negedge clk) begin
    if (rst_b) begin
      if (rdLast) begin
        if (rdQ.size() == 0) bad("unexpected read");
        else begin
          e = rdQ.pop_front();
          chk(e[10] ? {6'h00, tagReadback, rdData} : {8'h00, rdData}, {6'h00, e[9:0]}, "read data");
        end
      end
      if (txOutValid && txOutReady) begin
        if (txQ.size() == 0) bad("unexpected transmit byte");
        else chk({6'h00, txOut}, {6'h00, txQ.pop_front()}, "transmit byte");
      end
      if (rxFifoWrValid) begin
        if (rxQ.size() == 0) bad("unexpected rx fifo write");
        else chk({6'h00, rxFifoWr}, {6'h00, rxQ.pop_front()}, "rx fifo byte");
      end
    end
  end

  initial begin
    #400000;
    bad("watchdog expired");
    testDone();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    cpuReq = '0;
    cpuTx = '0;
    cpuTxValid = 1'b0;
    rxFifoRdStb = 1'b0;
    repeatCountBit = 1'b0;
    transmitterEnableBit = 1'b1;
    rxIn = '0;
    rxInValid = 1'b0;
    receiveBitClock = 1'b0;
    serialTestIn = 1'b0;
    lineRxIn = 1'b0;
    addrCompare = 16'h0000;
    slow = 1'b1;
    cnt = 0;
    len = 0;
    rst_b = 1'b0;
    void'($urandom(32'h79C04A3E));
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rd(5'h19, 8'h00);
    rd(5'h1A, 8'h00);
    rd(5'h05, 8'h00);
    len = 3;
    cnt = 3;
    wr(5'h19, 8'h03);
    repeat (3) txWr(hdlc_tc_pkg::tagged_byte_t'({2'b00, 8'($urandom)}), 0);
    rd(5'h19, 8'h00);
    repeatCountBit = 1'b1;
    len = 2;
    cnt = 2;
    wr(5'h19, 8'h02);
    repeat (5) txWr(hdlc_tc_pkg::tagged_byte_t'({2'b00, 8'($urandom)}), 0);
    rd(5'h19, 8'(cnt));
    repeat (60) @(negedge clk);
    repeatCountBit = 1'b0;
    wr(5'h1A, 8'h80);
    chk(16'(hdlcHeldInReset), 16'h0001, "soft reset not held");
    rd(5'h19, 8'h00);
    wr(5'h19, 8'h05);
    rd(5'h19, 8'h00);
    wr(5'h1A, 8'h00);
    chk(16'(hdlcHeldInReset), 16'h0001, "released after one zero write");
    wr(5'h1A, 8'h00);
    chk(16'(hdlcHeldInReset), 16'h0000, "not released after two zero writes");
    rd(5'h1A, 8'h00);
    pop(10'h000, 1'b1);
    cnt = 0;
    slow = 1'b0;
    wr(5'h1A, 8'h40);
    for (int i = 0; i < 12; i++) rxByte(hdlc_tc_pkg::rx_byte_t'(11'($urandom)));
    repeat (20) @(negedge clk);
    wr(5'h1A, 8'h00);
    transmitterEnableBit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      fb[i] = hdlc_tc_pkg::tagged_byte_t'(10'($urandom));
      txWr(fb[i], 2);
    end
    wr(5'h1A, 8'h04);
    for (int i = 0; i < 3; i++) pop(fb[i]);
    pop(10'h000);
    txWr(hdlc_tc_pkg::tagged_byte_t'(10'($urandom)), 1);
    wr(5'h1A, 8'h00);
    transmitterEnableBit = 1'b1;
    wr(5'h1A, 8'h08);
    shift(16'hF0B8, 16);
    chk(16'(crcMatchFlag), 16'h0001, "crc remainder not matched");
    shift(16'h0000, 1);
    chk(16'(crcMatchFlag), 16'h0001, "shift did not stop at 16");
    for (int k = 0; k < 16; k++) begin
      wr(5'h1A, 8'h00);
      wr(5'h1A, 8'h08);
      shift(16'hF0B8 ^ (16'h0001 << k), 16);
      chk(16'(crcMatchFlag), 16'h0000, "corrupted crc bit matched");
    end
    addrCompare = 16'($urandom);
    wr(5'h1A, 8'h02);
    shift(addrCompare, 16);
    chk(16'(addressMatchFlag), 16'h0001, "address not matched");
    wr(5'h1A, 8'h00);
    wr(5'h1A, 8'h02);
    shift(~addrCompare, 16);
    chk(16'(addressMatchFlag), 16'h0000, "wrong address matched");
    wr(5'h1A, 8'h01);
    repeat (8) begin
      @(negedge clk);
      chk(16'(rxSerialOut), 16'(txSerPrev), "transmit serial not looped");
    end
    wr(5'h1A, 8'h00);
    lineRxIn = 1'b1;
    repeat (6) @(negedge clk);
    chk(16'(rxSerialOut), 16'h0001, "line input not selected");
    repeat (20) @(negedge clk);
    chk(16'(txQ.size() + rxQ.size() + rdQ.size()), 16'h0000, "results left over");
    testDone();
  end
endmodule
